/* File: rtl/ppreg_pkg.sv */
// Constants and types of the parallel port register block.
// Assumes one 50 MHz core clock for every user.
package ppreg_pkg;

    // Register offsets within the eight-byte window
    localparam logic [2:0] OFS_DATA    = 3'h0;
    localparam logic [2:0] OFS_STATUS  = 3'h1;
    localparam logic [2:0] OFS_CONTROL = 3'h2;
    localparam logic [2:0] OFS_EADDR   = 3'h3;
    localparam logic [2:0] OFS_EDATA0  = 3'h4;
    localparam logic [2:0] OFS_EDATA3  = 3'h7;

    // Status bit positions
    localparam int ST_CYCLE_TIMEOUT_FLAG = 0;
    localparam int ST_FAULT = 3;
    localparam int ST_ONLINE_STATUS_INPUT  = 4;
    localparam int ST_PAPER = 5;
    localparam int ST_ACK   = 6;
    localparam int ST_READY = 7;

    // Control bit positions
    localparam int CT_STROBE = 0;
    localparam int CT_LFEED  = 1;
    localparam int CT_INIT   = 2;
    localparam int CT_SELIN  = 3;
    localparam int CT_INTERRUPT_REQUEST_ENABLE_BIT   = 4;
    localparam int CT_DIR    = 5;
    localparam int CT_WIDTH  = 6;

    // Reset values
    localparam logic [7:0]          DATA_RST = 8'h00;
    localparam logic [CT_WIDTH-1:0] CTL_RST  = 6'h00;
    localparam logic [7:0]          ZERO_BYTE = 8'h00;

    // Operating modes from the configuration block
    typedef enum logic [1:0] {
        PPREG_MODE_PRINTER = 2'h0,
        PPREG_MODE_BIDIR   = 2'h1,
        PPREG_MODE_ENH     = 2'h2
    } ppreg_mode_t;

    // Enhanced transfer timeout
    localparam int CLK_PERIOD_NS = 20;
    localparam int TMO_NS        = 10000;
    localparam int TMO_CYCLES    = TMO_NS / CLK_PERIOD_NS;
    localparam int TMO_CW        = 10;

    // Transfer engine states, one bit changes per step except TERM back to IDLE
    typedef enum logic [1:0] {
        PPREG_ST_IDLE = 2'b00,
        PPREG_ST_STRB = 2'b01,
        PPREG_ST_TERM = 2'b11
    } ppreg_state_t;

endpackage : ppreg_pkg

/* File: rtl/ppreg_epp_if.sv */
// Interface between the register block and its enhanced transfer engine.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ps
`default_nettype none
interface ppreg_epp_if;
    logic       start;     // One-cycle request to run a transfer
    logic       is_addr;   // Address cycle rather than data cycle
    logic       is_write;  // Write cycle (already gated by direction bit)
    logic       done;      // One-cycle pulse at the end of a transfer
    logic       timeout;   // Qualifies done: transfer was aborted
    logic [7:0] rdata;     // Byte captured at strobe release
    logic       active;    // A transfer owns the link
    logic       dstb;      // Data strobe asserted
    logic       astb;      // Address strobe asserted

    modport regs   (output start, is_addr, is_write, input done, timeout, rdata, active, dstb, astb);
    modport engine (input start, is_addr, is_write, output done, timeout, rdata, active, dstb, astb);
endinterface : ppreg_epp_if
`default_nettype wire

/* File: rtl/ppreg_epp_engine.sv */
// Enhanced-mode strobe/wait transfer engine with the 10 us watchdog.
// Assumes the wait input is synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module ppreg_epp_engine
    import ppreg_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    ppreg_epp_if.engine     epp,
    input  wire logic       peripheral_wait_low,
    input  wire logic [7:0] pd_in
);
    ppreg_state_t      state_r, state_nxt;   // Sequencer state
    logic [TMO_CW-1:0] cnt_r, cnt_nxt;       // Watchdog count
    logic              addr_r, addr_nxt;     // Address cycle latched
    logic [7:0]        rdat_r, rdat_nxt;     // Captured peripheral byte
    logic              done_r, done_nxt;     // Completion pulse
    logic              tmo_r, tmo_nxt;       // Abort indication

    // Next-state logic: strobe until wait releases or the watchdog fires
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        addr_nxt  = addr_r;
        rdat_nxt  = rdat_r;
        done_nxt  = 1'b0;
        tmo_nxt   = tmo_r;
        case (state_r)
            PPREG_ST_IDLE:
            begin
                if (epp.start)
                begin
                    state_nxt = PPREG_ST_STRB;
                    cnt_nxt   = '0;
                    addr_nxt  = epp.is_addr;
                    tmo_nxt   = 1'b0;
                end
            end
            PPREG_ST_STRB:
            begin
                // Peripheral ready: drop strobe and latch the bus
                if (peripheral_wait_low)
                begin
                    state_nxt = PPREG_ST_TERM;
                    rdat_nxt  = pd_in;
                end
                // Watchdog expiry aborts so the host never locks up
                else if (cnt_r == TMO_CW'(TMO_CYCLES - 1))
                begin
                    state_nxt = PPREG_ST_TERM;
                    tmo_nxt   = 1'b1;
                    rdat_nxt  = ZERO_BYTE;
                end
                else
                begin
                    cnt_nxt = cnt_r + TMO_CW'(1);
                end
            end
            PPREG_ST_TERM:
            begin
                // Strobe already released; report back to the host side
                state_nxt = PPREG_ST_IDLE;
                done_nxt  = 1'b1;
            end
            default:
            begin
                state_nxt = PPREG_ST_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= PPREG_ST_IDLE;
            cnt_r   <= '0;
            addr_r  <= 1'b0;
            rdat_r  <= ZERO_BYTE;
            done_r  <= 1'b0;
            tmo_r   <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            addr_r  <= addr_nxt;
            rdat_r  <= rdat_nxt;
            done_r  <= done_nxt;
            tmo_r   <= tmo_nxt;
        end
    end

    // Outputs toward the register block
    assign epp.done    = done_r;
    assign epp.timeout = tmo_r;
    assign epp.rdata   = rdat_r;
    assign epp.active  = (state_r != PPREG_ST_IDLE);
    assign epp.dstb    = (state_r == PPREG_ST_STRB) && !addr_r;
    assign epp.astb    = (state_r == PPREG_ST_STRB) && addr_r;

endmodule : ppreg_epp_engine
`default_nettype wire

/* File: rtl/ppreg_top.sv */
// Host register block of a printer port with bidirectional and enhanced modes.
// Assumes a host I/O port with a one-cycle request pulse, synchronous pins,
// and static configuration inputs.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Data write latches byte onto lines; reset zero
// - Standard data read returns live line levels
// - Status held stable during host read
// - Timeout bit set after 10 us cycle
// - Timeout clears on read or write-one
// - Reset clears timeout flag always
// - Status bits 1,2 read zero
// - Status 3..6 mirror fault/select/paper/ack inputs
// - Status bit 7 is inverted busy
// - Control bits 6,7 fixed zero; reset 0..5
// - Control bits 0,1,3 inverted to pins
// - Control bit 2 drives initialise directly
// - Enabled ack rising edge raises interrupt
// - Direction bit ignored in printer mode
// - Offset 3 write runs address write cycle; with direction bit set it runs an address read cycle
// - Offset 3 read captures at strobe release
// - Offsets 4-7 write run data write; with direction bit set they run a data read cycle
// - Offsets 4-7 read capture at strobe release
// - Enhanced offsets only in enhanced mode
// - Timed-out cycle aborts, flag reports it
// - Wait states until peripheral releases wait
module ppreg_top
    import ppreg_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire ppreg_pkg::ppreg_mode_t cfg_mode,
    input  wire logic              cfg_timeout_clear_sel,
    input  wire logic              io_req,
    input  wire logic              io_write,
    input  wire logic [2:0]        io_addr,
    input  wire logic [7:0]        io_wdata,
    output logic      [7:0]        io_rdata,
    output logic                   io_ready,
    input  wire logic [7:0]        pd_in,
    output logic      [7:0]        pd_out,
    output logic                   pd_oe,
    input  wire logic              fault_input_low,
    input  wire logic              online_status_input,
    input  wire logic              paper_out_input,
    input  wire logic              acknowledge_input_low,
    input  wire logic              busy_wait_input,
    output logic                   data_strobe_output_low,
    output logic                   line_feed_output_low,
    output logic                   initialise_output,
    output logic                   select_in_output_low,
    output logic                   port_irq
);
    import ppreg_pkg::*;

    ppreg_epp_if epp ();                       // Link to the transfer engine

    logic [7:0]          data_r, data_nxt;     // Output data latch
    logic [CT_WIDTH-1:0] ctl_r, ctl_nxt;       // Control bits 0..5 only
    logic [7:0]          eaddr_r, eaddr_nxt;   // Enhanced address register
    logic [7:0]          ewr_r, ewr_nxt;       // Byte held for a data write
    logic                tmo_r, tmo_nxt;       // Cycle timeout flag
    logic                busy_r, busy_nxt;     // Host waiting on engine
    logic                rd_r, rd_nxt;         // Pending transfer is a read
    logic                start_r, start_nxt;   // Engine start pulse
    logic                addr_c_r, addr_c_nxt; // Pending transfer is address
    logic                wr_c_r, wr_c_nxt;     // Pending transfer writes
    logic                stat_rd_r, stat_rd_nxt; // Answer closes a status read
    logic [7:0]          rdat_r, rdat_nxt;     // Held read answer
    logic                rdy_r, rdy_nxt;       // Answer pulse
    logic                ack_q_r;              // Previous acknowledge level
    logic                irq_r, irq_nxt;       // Interrupt pulse
    logic [7:0]          status_w;             // Live status assembly
    logic                enh_mode;             // Enhanced offsets usable
    logic                enh_ofs;              // Request targets offsets 3..7

    // Transfer engine
    ppreg_epp_engine u_engine (
        .core_clk            (core_clk),
        .rstn                (rstn),
        .epp                 (epp.engine),
        .peripheral_wait_low (busy_wait_input),
        .pd_in               (pd_in)
    );

    assign enh_mode = (cfg_mode == PPREG_MODE_ENH);
    assign enh_ofs  = (io_addr >= OFS_EADDR);

    // Status byte built from the pins each time it is sampled
    always_comb
    begin
        status_w           = ZERO_BYTE;              // Bits 1,2 stay low
        status_w[ST_CYCLE_TIMEOUT_FLAG] = tmo_r;
        status_w[ST_FAULT] = fault_input_low;
        status_w[ST_ONLINE_STATUS_INPUT]  = online_status_input;
        status_w[ST_PAPER] = paper_out_input;
        status_w[ST_ACK]   = acknowledge_input_low;
        status_w[ST_READY] = ~busy_wait_input;
    end

    // Host access decode, register updates and answer timing
    always_comb
    begin
        data_nxt    = data_r;
        ctl_nxt     = ctl_r;
        eaddr_nxt   = eaddr_r;
        ewr_nxt     = ewr_r;
        tmo_nxt     = tmo_r;
        busy_nxt    = busy_r;
        rd_nxt      = rd_r;
        start_nxt   = 1'b0;
        addr_c_nxt  = addr_c_r;
        wr_c_nxt    = wr_c_r;
        stat_rd_nxt = 1'b0;
        rdat_nxt    = rdat_r;
        rdy_nxt     = 1'b0;
        irq_nxt     = 1'b0;

        // Status-read clear takes effect as the read answer leaves
        if (stat_rd_r && !cfg_timeout_clear_sel)
        begin
            tmo_nxt = 1'b0;
        end

        if (io_req && !busy_r)
        begin
            if (enh_ofs && enh_mode)
            begin
                // Start a transfer; host is held in wait states
                busy_nxt   = 1'b1;
                start_nxt  = 1'b1;
                rd_nxt     = !io_write;
                addr_c_nxt = (io_addr == OFS_EADDR);
                // Direction bit set forces a read on the link
                wr_c_nxt   = io_write && !ctl_r[CT_DIR];
                if (io_write && io_addr == OFS_EADDR)
                begin
                    eaddr_nxt = io_wdata;
                end
                else if (io_write)
                begin
                    ewr_nxt = io_wdata;
                end
            end
            else
            begin
                rdy_nxt = 1'b1;
                if (enh_ofs)
                begin
                    // Not enhanced mode: ignored writes, zero reads
                    rdat_nxt = io_write ? rdat_r : ZERO_BYTE;
                end
                else if (io_write)
                begin
                    case (io_addr)
                        OFS_DATA:    data_nxt = io_wdata;
                        OFS_CONTROL: ctl_nxt  = io_wdata[CT_WIDTH-1:0]; // Bits 6,7 dropped
                        OFS_STATUS:
                        begin
                            if (cfg_timeout_clear_sel && io_wdata[ST_CYCLE_TIMEOUT_FLAG])
                            begin
                                tmo_nxt = 1'b0;
                            end
                        end
                        default:     data_nxt = data_r;
                    endcase
                end
                else
                begin
                    case (io_addr)
                        OFS_DATA:    rdat_nxt = pd_in;                  // Live lines
                        OFS_STATUS:
                        begin
                            rdat_nxt    = status_w;                     // Frozen for the read
                            stat_rd_nxt = 1'b1;
                        end
                        OFS_CONTROL: rdat_nxt = {2'b00, ctl_r};
                        default:     rdat_nxt = ZERO_BYTE;
                    endcase
                end
            end
        end

        // Transfer finished or aborted: release the host
        if (busy_r && epp.done)
        begin
            busy_nxt = 1'b0;
            rdy_nxt  = 1'b1;
            if (rd_r)
            begin
                rdat_nxt = epp.rdata;
            end
            if (epp.timeout)
            begin
                tmo_nxt = 1'b1;                           // Set beats clear
            end
        end

        // Interrupt on a rising acknowledge while enabled
        if (ctl_r[CT_INTERRUPT_REQUEST_ENABLE_BIT] && acknowledge_input_low && !ack_q_r)
        begin
            irq_nxt = 1'b1;
        end
    end

    // Register bank; reset clears data, address, control 0..5 and timeout
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            data_r    <= DATA_RST;
            ctl_r     <= CTL_RST;
            eaddr_r   <= DATA_RST;
            ewr_r     <= DATA_RST;
            tmo_r     <= 1'b0;
            busy_r    <= 1'b0;
            rd_r      <= 1'b0;
            start_r   <= 1'b0;
            addr_c_r  <= 1'b0;
            wr_c_r    <= 1'b0;
            stat_rd_r <= 1'b0;
            rdat_r    <= ZERO_BYTE;
            rdy_r     <= 1'b0;
            ack_q_r   <= 1'b1;     // Idle pin level, so no false edge after reset
            irq_r     <= 1'b0;
        end
        else
        begin
            data_r    <= data_nxt;
            ctl_r     <= ctl_nxt;
            eaddr_r   <= eaddr_nxt;
            ewr_r     <= ewr_nxt;
            tmo_r     <= tmo_nxt;
            busy_r    <= busy_nxt;
            rd_r      <= rd_nxt;
            start_r   <= start_nxt;
            addr_c_r  <= addr_c_nxt;
            wr_c_r    <= wr_c_nxt;
            stat_rd_r <= stat_rd_nxt;
            rdat_r    <= rdat_nxt;
            rdy_r     <= rdy_nxt;
            ack_q_r   <= acknowledge_input_low;
            irq_r     <= irq_nxt;
        end
    end

    // Engine request fields
    assign epp.start    = start_r;
    assign epp.is_addr  = addr_c_r;
    assign epp.is_write = wr_c_r;

    // Data lines: transfer byte while a write transfer owns the link
    always_comb
    begin
        if (epp.active && wr_c_r)
        begin
            pd_out = addr_c_r ? eaddr_r : ewr_r;         // Held whole cycle
            pd_oe  = 1'b1;
        end
        else if (epp.active)
        begin
            pd_out = data_r;
            pd_oe  = 1'b0;                               // Read transfer listens
        end
        else
        begin
            pd_out = data_r;
            // Printer mode always drives; others follow direction
            pd_oe  = (cfg_mode == PPREG_MODE_PRINTER) || !ctl_r[CT_DIR];
        end
    end

    // Control pins; during a transfer strobes and write indicator take over
    assign data_strobe_output_low = epp.active ? !wr_c_r : !ctl_r[CT_STROBE];
    assign line_feed_output_low   = epp.dstb ? 1'b0 : !ctl_r[CT_LFEED];
    assign initialise_output      = ctl_r[CT_INIT];
    assign select_in_output_low   = epp.astb ? 1'b0 : !ctl_r[CT_SELIN];

    assign io_rdata = rdat_r;
    assign io_ready = rdy_r;
    assign port_irq = irq_r;

endmodule : ppreg_top
`default_nettype wire

/* File: sim/ppreg_assertions.sv */
// Checker for the parallel port register block.
// Assumes binding into ppreg_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ppreg_assertions (
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic [1:0] cfg_mode,
    input wire logic       io_req,
    input wire logic       io_write,
    input wire logic [2:0] io_addr,
    input wire logic [7:0] io_rdata,
    input wire logic       io_ready,
    input wire logic [7:0] pd_out,
    input wire logic       pd_oe,
    input wire logic       fault_input_low,
    input wire logic       online_status_input,
    input wire logic       paper_out_input,
    input wire logic       acknowledge_input_low,
    input wire logic       busy_wait_input,
    input wire logic       data_strobe_output_low,
    input wire logic       line_feed_output_low,
    input wire logic       select_in_output_low,
    input wire logic       port_irq
);
    import ppreg_pkg::*;
    logic pend_r;   // Enhanced transfer outstanding
    logic pend_nxt; // Next value of pend_r
    logic enh;      // Enhanced mode selected
    assign enh = (cfg_mode == PPREG_MODE_ENH);
    // Track a transfer from its request to its answer
    always_comb
    begin
        pend_nxt = pend_r ? !io_ready : (io_req && enh && io_addr >= OFS_EADDR);
    end
    // Register the tracker
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            pend_r <= 1'b0;
        else
            pend_r <= pend_nxt;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Data write strobe phase with the lines driven
    sequence s_wr_strobe;
        enh && !line_feed_output_low && !data_strobe_output_low && pd_oe;
    endsequence
    // First sight of a released wait while a strobe is out
    sequence s_wait_seen;
        pend_r && $past(pend_r) && !(line_feed_output_low && select_in_output_low) &&
            busy_wait_input && !$past(busy_wait_input);
    endsequence
    AST_PLAIN_ANSWER: assert property (!enh && io_req |=> io_ready)
        else $error("No answer next cycle");
    AST_STATUS_LAYOUT: assert property (io_req && !io_write && io_addr == OFS_STATUS && !pend_r |=>
        io_rdata[7:1] == {!$past(busy_wait_input), $past(acknowledge_input_low), $past(paper_out_input),
        $past(online_status_input), $past(fault_input_low), 2'b00})
        else $error("Status byte wrong");
    AST_CTL_TOP_ZERO: assert property (io_req && !io_write && io_addr == OFS_CONTROL && !pend_r |=>
        io_rdata[7:6] == 2'b00) else $error("Control bits 7:6 set");
    AST_ENH_OFF_ZERO: assert property (!enh && io_req && !io_write && io_addr >= OFS_EADDR |=>
        io_rdata == ZERO_BYTE) else $error("Enhanced offset read nonzero");
    AST_PRINTER_DRIVE: assert property (cfg_mode == PPREG_MODE_PRINTER |-> pd_oe)
        else $error("Lines not driven");
    AST_IRQ_CAUSE: assert property (port_irq |-> $past(acknowledge_input_low) &&
        (!$past(acknowledge_input_low, 2) || !$past(acknowledge_input_low, 3)))
        else $error("Interrupt without ack edge");
    AST_WRITE_HOLD: assert property (s_wr_strobe ##1 s_wr_strobe |-> $stable(pd_out) || $past(io_req))
        else $error("Lines moved under write strobe");
    AST_WAIT_RELEASE: assert property (s_wait_seen |-> ##3 io_ready)
        else $error("No answer after wait release");
    AST_TRANSFER_BOUND: assert property ($rose(pend_r) |-> ##[3:503] io_ready)
        else $error("Transfer exceeded timeout bound");
endmodule : ppreg_assertions
bind ppreg_top ppreg_assertions u_chk (.*);
`default_nettype wire

/* File: sim/ppreg_periph_model.sv */
// Enhanced peripheral: releases wait a set delay after a strobe (zero: never)
// and drives reply_byte on reads. Assumes link_on marks enhanced mode.
`timescale 1ns/1ps
`default_nettype none
module ppreg_periph_model (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        link_on,
    input wire logic [7:0]  pd_out,
    input wire logic        pd_oe,
    input wire logic        line_feed_output_low,
    input wire logic        select_in_output_low,
    input wire logic [9:0]  wait_delay,
    input wire logic [7:0]  reply_byte,
    input wire logic        busy_idle,
    output logic     [7:0]  pd_in,
    output logic            busy_wait_input
);
    logic       strobe; // Either strobe asserted by the block
    logic       hs_r;   // Wait released
    logic [9:0] cnt_r;  // Cycles since strobe went out
    logic [7:0] last_r; // Last wire value, inverted once released
    assign strobe = link_on && !(line_feed_output_low && select_in_output_low);
    assign busy_wait_input = link_on ? hs_r : busy_idle;
    // Release wait after the delay; re-assert once the strobe drops
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_r <= 10'h000;
            hs_r  <= 1'b0;
        end
        else if (!strobe)
        begin
            cnt_r <= 10'h000;
            hs_r  <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_r + 10'h001;
            if (wait_delay != 10'h000 && cnt_r == wait_delay)
                hs_r <= 1'b1;
        end
        last_r <= pd_in;
    end
    // Wire: block, else peripheral reply, else inverted last level
    always_comb
    begin
        if (pd_oe)
            pd_in = pd_out;
        else if (strobe)
            pd_in = reply_byte;
        else
            pd_in = ~last_r;
    end
endmodule : ppreg_periph_model
`default_nettype wire

/* File: sim/parallel_port_spp_epp_registers_bench.sv */
// Self-checking bench for the parallel port register block.
// Assumes ppreg_top, the peripheral model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; $display("BAD %s expected %h seen %h", nm, e, g); end end
module parallel_port_spp_epp_registers_bench;
    import ppreg_pkg::*;
    logic core_clk = 0, rstn = 0, cfg_timeout_clear_sel = 0, io_req = 0, io_write = 0, io_ready, pd_oe, port_irq;
    logic fault_input_low = 1, online_status_input = 0, paper_out_input = 0, acknowledge_input_low = 1;
    logic busy_idle = 0, busy_wait_input, data_strobe_output_low, line_feed_output_low, initialise_output;
    logic select_in_output_low;
    logic [2:0] io_addr = 3'h0;
    logic [7:0] io_wdata = 8'h00, io_rdata, pd_in, pd_out, reply_byte = 8'h00, q, bus;
    logic [9:0] wait_delay = 10'h005;
    ppreg_mode_t cfg_mode = PPREG_MODE_PRINTER;
    int num_errors = 0, samples_checked = 0, cyc = 0, lat;
    ppreg_top u_dut (.*);
    ppreg_periph_model u_periph (.*, .link_on(cfg_mode == PPREG_MODE_ENH));
    always #10 core_clk = ~core_clk;
    // Hang guard, far above the run length
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // Reset into a new static configuration
    task automatic do_reset(input ppreg_mode_t m, input logic s);
        rstn <= 1'b0;
        cfg_mode <= m;
        cfg_timeout_clear_sel <= s;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
    endtask : do_reset
    // One host request; notes the byte under a strobe
    task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        io_req <= 1'b1;
        io_write <= wr;
        io_addr <= a;
        io_wdata <= d;
        @(posedge core_clk);
        io_req <= 1'b0;
        lat = 1;
        #1;
        while (io_ready !== 1'b1 && lat < 600)
        begin
            if (pd_oe && !(line_feed_output_low && select_in_output_low))
                bus = pd_out;
            @(posedge core_clk);
            #1;
            lat++;
        end
        q = io_rdata;
        `CHK("answer", 1'b1, lat < 600)
    endtask : xfer
    task automatic test_printer();
        do_reset(PPREG_MODE_PRINTER, 1'b0);
        `CHK("pd_out reset", 8'h00, pd_out)
        `CHK("pins reset", 4'b1110, {data_strobe_output_low, line_feed_output_low, select_in_output_low,
            initialise_output})
        xfer(1'b0, OFS_CONTROL, 8'h00);
        `CHK("ctl reset", 8'h00, q)
        xfer(1'b1, OFS_DATA, 8'hA5);
        `CHK("pd_out", 8'hA5, pd_out)
        xfer(1'b0, OFS_DATA, 8'h00);
        `CHK("data read", 8'hA5, q)
        xfer(1'b1, OFS_CONTROL, 8'hFF);
        xfer(1'b0, OFS_CONTROL, 8'h00);
        `CHK("ctl read", 8'h3F, q)
        `CHK("pins set", 5'b00011, {data_strobe_output_low, line_feed_output_low, select_in_output_low,
            initialise_output, pd_oe})
        {fault_input_low, online_status_input, paper_out_input, acknowledge_input_low, busy_idle} <= 5'b10101;
        xfer(1'b0, OFS_STATUS, 8'h00);
        `CHK("status", 8'h28, q)
        xfer(1'b1, OFS_EDATA0, 8'h5A);
        xfer(1'b0, OFS_EDATA0, 8'h00);
        `CHK("enh off", 16'h00A5, {q, pd_out})
        $display("test_printer done");
    endtask : test_printer
    task automatic test_irq();
        do_reset(PPREG_MODE_BIDIR, 1'b0);
        xfer(1'b1, OFS_CONTROL, 8'h20);
        `CHK("bidir input", 1'b0, pd_oe)
        for (int en = 1; en >= 0; en--)
        begin
            xfer(1'b1, OFS_CONTROL, en ? 8'h10 : 8'h00);
            acknowledge_input_low <= 1'b0;
            repeat (3) @(posedge core_clk);
            acknowledge_input_low <= 1'b1;
            bus = 8'h00;
            repeat (4) @(posedge core_clk) #1 bus[0] = bus[0] | port_irq;
            `CHK("irq", en[0], bus[0])
        end
        $display("test_irq done");
    endtask : test_irq
    task automatic test_enh();
        do_reset(PPREG_MODE_ENH, 1'b0);
        xfer(1'b1, OFS_CONTROL, 8'h04);
        xfer(1'b1, OFS_EADDR, 8'h3C);
        `CHK("addr write", 9'h13C, {lat >= 4, bus})
        for (int a = 4; a <= 7; a++)
        begin
            xfer(1'b1, 3'(a), 8'h40 + 8'(a));
            `CHK("data write", 8'h40 + 8'(a), bus)
        end
        reply_byte <= 8'h96;
        xfer(1'b0, OFS_EDATA3, 8'h00);
        `CHK("data read", 8'h96, q)
        reply_byte <= 8'h5A;
        xfer(1'b0, OFS_EADDR, 8'h00);
        `CHK("addr read", 8'h5A, q)
        $display("test_enh done");
    endtask : test_enh
    task automatic test_timeout(input logic s);
        do_reset(PPREG_MODE_ENH, s);
        xfer(1'b1, OFS_CONTROL, 8'h04);
        wait_delay <= 10'h000;
        xfer(1'b0, 3'h5, 8'h00);
        `CHK("aborted read", 9'h100, {lat == 504, q})
        xfer(1'b0, OFS_STATUS, 8'h00);
        `CHK("flag set", 1'b1, q[0])
        xfer(1'b0, OFS_STATUS, 8'h00);
        `CHK("flag after read", s, q[0])
        xfer(1'b1, OFS_STATUS, 8'h01);
        xfer(1'b0, OFS_STATUS, 8'h00);
        `CHK("flag after write", 1'b0, q[0])
        xfer(1'b1, OFS_EDATA0, 8'h11);
        do_reset(PPREG_MODE_ENH, s);
        xfer(1'b0, OFS_STATUS, 8'h00);
        `CHK("flag after reset", 1'b0, q[0])
        wait_delay <= 10'h005;
        $display("test_timeout done");
    endtask : test_timeout
    initial
    begin
        test_printer();
        test_irq();
        test_enh();
        test_timeout(1'b0);
        test_timeout(1'b1);
        tally_and_finish();
    end
endmodule : parallel_port_spp_epp_registers_bench
`default_nettype wire
